// ===== design/output_disable_input_detect.sv
// Four active-low disable-request detectors with flags, interrupt and register port.
// Assumes a single-cycle strobe master on the same clock; request pins are asynchronous.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - In mode 0000 a falling edge on the request pin sets the channel's detection.
// - Modes 0001, 0010 and 0011 sample the pin at the clock divided by 8, 16 and 128.
// - Modes 0100, 0101 and 0110 sample the pin at the clock, half of it and a quarter of it.
// - A sampling mode detects only after the sample count select value plus one consecutive low samples.
// - Each channel has its own four-bit sample count select that sets the low run needed.
// - A channel's flag is set when the condition chosen by its mode and count occurs.
// - A flag clears only on a write of 0 that follows a read that returned it as 1.
// - In sampling modes the clearing write works only while the pin is back high.
module output_disable_input_detect
  import odid_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  // Request pins
  input  wire logic              disable_request_pin_b_n_i,
  input  wire logic              disable_request_pin_c_n_i,
  input  wire logic              disable_request_pin_d_n_i,
  input  wire logic              disable_request_pin_e_n_i,
  // To output high-impedance control
  output logic      [NUM_CH-1:0] disable_req_o,
  // Interrupt
  output logic                   irq_o
);

  //////////////////////////////////////////////////////////////////////////////
  // State

  logic [PRESC_W-1:0]   presc_reg;
  logic [NUM_TICKS-1:0] div_tick;
  logic [NUM_CH-1:0]    pins_n;
  logic [3:0]           mode_reg [NUM_CH];
  logic [3:0]           sel_reg  [NUM_CH];
  logic [NUM_CH-1:0]    flag_reg;
  logic [NUM_CH-1:0]    armed_reg;
  logic [NUM_CH-1:0]    detect;
  logic [NUM_CH-1:0]    pin_high;
  logic [NUM_CH-1:0]    sampling;
  logic [NUM_CH-1:0]    hit_wr;
  logic [NUM_CH-1:0]    hit_rd;
  logic [NUM_CH-1:0]    clear_ok;
  logic [NUM_CH-1:0]    irq_stat_reg;
  logic [NUM_CH-1:0]    irq_mask_reg;
  logic                 irq_reg;
  logic                 stat_rd;
  logic                 mask_wr;
  logic [DATA_W-1:0]    rdata_reg;
  logic [DATA_W-1:0]    rdata_next;

  assign pins_n = {disable_request_pin_e_n_i, disable_request_pin_d_n_i,
                   disable_request_pin_c_n_i, disable_request_pin_b_n_i};

  //////////////////////////////////////////////////////////////////////////////
  // Shared prescaler; all taps line up so divided samples stay phase-related

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      presc_reg <= 7'h00;
    end else begin
      presc_reg <= presc_reg + 7'h01;
    end
  end

  generate
    for (genvar t = 0; t < NUM_TICKS; t++) begin : g_tick
      assign div_tick[t] = (presc_reg & DIV_MASK[t]) == DIV_MASK[t];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Per-channel detector, configuration and flag

  generate
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch

      assign hit_wr[g] = reg_wr_i && (reg_addr_i == CH_OFS[g]);
      assign hit_rd[g] = reg_rd_i && (reg_addr_i == CH_OFS[g]);

      input_detect_channel u_det (
        .sys_clk_i   (sys_clk_i),
        .rst_n_i     (rst_n_i),
        .req_pin_n_i (pins_n[g]),
        .mode_i      (mode_reg[g]),
        .count_sel_i (sel_reg[g]),
        .div_tick_i  (div_tick),
        .detect_o    (detect[g]),
        .pin_high_o  (pin_high[g]),
        .sampling_o  (sampling[g])
      );

      // Forbidden codes are stored as written but never detect
      always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          mode_reg[g] <= MODE_RST;
        end else if (hit_wr[g]) begin
          mode_reg[g] <= reg_wdata_i[MODE_LSB +: 4];
        end
      end

      always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          sel_reg[g] <= SEL_RST;
        end else if (hit_wr[g]) begin
          sel_reg[g] <= reg_wdata_i[SEL_LSB +: 4];
        end
      end

      // Read of 1 arms the clear; any later write to the register disarms it
      always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          armed_reg[g] <= 1'b0;
        end else if (hit_rd[g] && flag_reg[g]) begin
          armed_reg[g] <= 1'b1;
        end else if (hit_wr[g] || !flag_reg[g]) begin
          armed_reg[g] <= 1'b0;
        end
      end

      assign clear_ok[g] = hit_wr[g] && !reg_wdata_i[FLAG_BIT] && armed_reg[g] &&
                           (!sampling[g] || pin_high[g]);

      // A new detection in the clearing cycle wins over the clear
      always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          flag_reg[g] <= 1'b0;
        end else if (detect[g]) begin
          flag_reg[g] <= 1'b1;
        end else if (clear_ok[g]) begin
          flag_reg[g] <= 1'b0;
        end
      end

      always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          irq_stat_reg[g] <= 1'b0;
        end else if (detect[g]) begin
          irq_stat_reg[g] <= 1'b1;
        end else if (stat_rd) begin
          irq_stat_reg[g] <= 1'b0;
        end
      end

    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Output-disable requests follow the flags directly

  assign disable_req_o = flag_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask

  assign stat_rd = reg_rd_i && (reg_addr_i == OFS_IRQ_STAT);
  assign mask_wr = reg_wr_i && (reg_addr_i == OFS_IRQ_MASK);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_mask_reg <= MASK_RST;
    end else if (mask_wr) begin
      irq_mask_reg <= reg_wdata_i[NUM_CH-1:0];
    end
  end

  // Registered for a clean level; lags the status bit by one cycle
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  assign irq_o = irq_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Read path; data valid only in the cycle after the strobe

  always_comb begin
    rdata_next = 16'h0000;
    unique case (reg_addr_i)
      OFS_CTRL_B, OFS_CTRL_C, OFS_CTRL_D, OFS_CTRL_E: begin
        for (int i = 0; i < NUM_CH; i++) begin
          if (reg_addr_i == CH_OFS[i]) begin
            rdata_next[MODE_LSB +: 4] = mode_reg[i];
            rdata_next[SEL_LSB +: 4]  = sel_reg[i];
            rdata_next[FLAG_BIT]      = flag_reg[i];
            rdata_next[PIN_BIT]       = pin_high[i];
          end
        end
      end
      OFS_IRQ_STAT: rdata_next[NUM_CH-1:0] = irq_stat_reg;
      OFS_IRQ_MASK: rdata_next[NUM_CH-1:0] = irq_mask_reg;
      default:      rdata_next = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 16'h0000;
    end else if (reg_rd_i) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= 16'h0000;
    end
  end

  assign reg_rdata_o = rdata_reg;

endmodule

`default_nettype wire

// ===== design/odid_pkg.sv
// Constants, field layout and types shared by the input-level detectors.
// Assumes one 50 MHz clock and a synchronous, active-low reset.
package odid_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Geometry
  localparam int unsigned NUM_CH      = 4;
  localparam int unsigned ADDR_W      = 4;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned NUM_TICKS   = 6;
  localparam int unsigned PRESC_W     = 7;
  localparam int unsigned CNT_W       = 5;

  //////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [3:0] OFS_CTRL_B   = 4'h0;
  localparam logic [3:0] OFS_CTRL_C   = 4'h2;
  localparam logic [3:0] OFS_CTRL_D   = 4'h4;
  localparam logic [3:0] OFS_CTRL_E   = 4'h6;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
  localparam logic [3:0] OFS_IRQ_MASK = 4'ha;
  localparam logic [3:0] CH_OFS [NUM_CH] = '{OFS_CTRL_B, OFS_CTRL_C, OFS_CTRL_D, OFS_CTRL_E};

  //////////////////////////////////////////////////////////////////////////////
  // Field positions in a channel register
  localparam int unsigned MODE_LSB    = 0;
  localparam int unsigned SEL_LSB     = 4;
  localparam int unsigned FLAG_BIT    = 12;
  localparam int unsigned PIN_BIT     = 13;

  //////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [3:0] MODE_RST     = 4'h0;
  localparam logic [3:0] SEL_RST      = 4'h0;
  localparam logic [3:0] MASK_RST     = 4'h0;
  localparam logic       SYNC_RST     = 1'h1;

  //////////////////////////////////////////////////////////////////////////////
  // Detection mode codes
  localparam logic [3:0] MODE_EDGE    = 4'h0;
  localparam logic [3:0] MODE_DIV8    = 4'h1;
  localparam logic [3:0] MODE_DIV16   = 4'h2;
  localparam logic [3:0] MODE_DIV128  = 4'h3;
  localparam logic [3:0] MODE_DIV1    = 4'h4;
  localparam logic [3:0] MODE_DIV2    = 4'h5;
  localparam logic [3:0] MODE_DIV4    = 4'h6;

  //////////////////////////////////////////////////////////////////////////////
  // Prescaler taps: tick k fires when the masked counter bits are all ones
  localparam int unsigned TICK_DIV1   = 0;
  localparam int unsigned TICK_DIV2   = 1;
  localparam int unsigned TICK_DIV4   = 2;
  localparam int unsigned TICK_DIV8   = 3;
  localparam int unsigned TICK_DIV16  = 4;
  localparam int unsigned TICK_DIV128 = 5;
  localparam logic [6:0] DIV_MASK [NUM_TICKS] =
    '{7'h00, 7'h01, 7'h03, 7'h07, 7'h0f, 7'h7f};

  typedef enum logic [1:0] {SMP_IDLE, SMP_COUNT, SMP_HELD} smp_state_t;

endpackage

// ===== design/input_detect_channel.sv
// One request-pin detector: synchroniser, falling-edge finder, low-level sampler.
// Assumes prescaler ticks come from the same clock, one cycle wide.
`timescale 1ns/1ns
`default_nettype none

module input_detect_channel
  import odid_pkg::*;
(
  // Clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_n_i,
  // Pin and configuration
  input  wire logic                 req_pin_n_i,
  input  wire logic [3:0]           mode_i,
  input  wire logic [3:0]           count_sel_i,
  input  wire logic [NUM_TICKS-1:0] div_tick_i,
  // Results
  output logic                      detect_o,
  output logic                      pin_high_o,
  output logic                      sampling_o
);

  logic             sync1_reg;
  logic             sync2_reg;
  logic             prev_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] need;
  smp_state_t       state_reg;
  logic             sample_en;
  logic             edge_hit;
  logic             level_hit;

  //////////////////////////////////////////////////////////////////////////////
  // Idle level of the pin is high, so reset there to avoid a false edge
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
      prev_reg  <= SYNC_RST;
    end else begin
      sync1_reg <= req_pin_n_i;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  assign pin_high_o = sync2_reg;
  assign edge_hit   = (mode_i == MODE_EDGE) && prev_reg && !sync2_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Sample rate per mode; forbidden codes never sample
  always_comb begin
    unique case (mode_i)
      MODE_DIV8:   sample_en = div_tick_i[TICK_DIV8];
      MODE_DIV16:  sample_en = div_tick_i[TICK_DIV16];
      MODE_DIV128: sample_en = div_tick_i[TICK_DIV128];
      MODE_DIV1:   sample_en = div_tick_i[TICK_DIV1];
      MODE_DIV2:   sample_en = div_tick_i[TICK_DIV2];
      MODE_DIV4:   sample_en = div_tick_i[TICK_DIV4];
      default:     sample_en = 1'b0;
    endcase
  end

  assign sampling_o = (mode_i >= MODE_DIV8) && (mode_i <= MODE_DIV4);
  assign need       = {1'b0, count_sel_i} + 5'h01;

  //////////////////////////////////////////////////////////////////////////////
  // Consecutive-low counter; one hit per low episode
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= SMP_IDLE;
      cnt_reg   <= 5'h00;
    end else if (!sampling_o) begin
      state_reg <= SMP_IDLE;
      cnt_reg   <= 5'h00;
    end else if (sample_en) begin
      unique case (state_reg)
        SMP_IDLE, SMP_COUNT: begin
          if (sync2_reg) begin
            state_reg <= SMP_IDLE;
            cnt_reg   <= 5'h00;
          end else if (cnt_reg + 5'h01 == need) begin
            state_reg <= SMP_HELD;
            cnt_reg   <= 5'h00;
          end else begin
            state_reg <= SMP_COUNT;
            cnt_reg   <= cnt_reg + 5'h01;
          end
        end
        SMP_HELD: begin
          if (sync2_reg) begin
            state_reg <= SMP_IDLE;
          end
        end
      endcase
    end
  end

  assign level_hit = sampling_o && sample_en && (state_reg != SMP_HELD) && !sync2_reg &&
                     (cnt_reg + 5'h01 == need);
  assign detect_o  = edge_hit || level_hit;

endmodule

`default_nettype wire

// ===== verification/odid_props.sv
// Checker for the input-level detectors, watching the top ports only.
// Assumes one clock and the one-cycle strobe register master.
`timescale 1ns/1ns
`default_nettype none

module odid_props
  import odid_pkg::*;
(
  // Clock and reset
  input wire logic              sys_clk_i,
  input wire logic              rst_n_i,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  // Pins and results
  input wire logic              disable_request_pin_b_n_i,
  input wire logic              disable_request_pin_c_n_i,
  input wire logic              disable_request_pin_d_n_i,
  input wire logic              disable_request_pin_e_n_i,
  input wire logic [NUM_CH-1:0] disable_req_o,
  input wire logic              irq_o
);
  logic       rst_n_dly_reg;
  logic [3:0] pin_n;
  default clocking @(posedge sys_clk_i); endclocking
  // Release edge masked too: flops still show X in the sample before it
  default disable iff (!rst_n_i || !rst_n_dly_reg);
  always_ff @(posedge sys_clk_i) begin
    rst_n_dly_reg <= rst_n_i;
  end
  assign pin_n = {disable_request_pin_e_n_i, disable_request_pin_d_n_i,
                  disable_request_pin_c_n_i, disable_request_pin_b_n_i};

  //////////////////////////////////////////////////////////////////////////////
  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data outside its slot");
  unmapped_zero_a: assert property (reg_rd_i && reg_addr_i == 4'hc |=> reg_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  cfg_readback_a: assert property (reg_wr_i && reg_addr_i == OFS_CTRL_B ##1
    reg_rd_i && reg_addr_i == OFS_CTRL_B |=> reg_rdata_o[7:0] == $past(reg_wdata_i[7:0], 2))
    else $error("mode or count not read back");
  irq_rise_a: assert property ($rose(irq_o) |-> $past(reg_wr_i, 2) || $past(|disable_req_o))
    else $error("interrupt without cause");
  irq_fall_a: assert property ($fell(irq_o) |-> $past(reg_rd_i, 2) || $past(reg_wr_i, 2))
    else $error("interrupt dropped without access");
  // Several cycles of slack, though the flag rises 3 cycles after the pin level that sets it: the falling edge, or the last low sample of the run
  for (genvar k = 0; k < NUM_CH; k++) begin : g_ch
    flag_view_a: assert property (reg_rd_i && reg_addr_i == CH_OFS[k] |=>
      reg_rdata_o[FLAG_BIT] == $past(disable_req_o[k])) else $error("flag read wrong");
    field_zero_a: assert property (reg_rd_i && reg_addr_i == CH_OFS[k] |=>
      reg_rdata_o[15:14] == 2'h0 && reg_rdata_o[11:8] == 4'h0) else $error("spare bits set");
    clear_cause_a: assert property ($fell(disable_req_o[k]) |-> $past(reg_wr_i) &&
      $past(reg_addr_i) == CH_OFS[k] && !$past(reg_wdata_i[FLAG_BIT]))
      else $error("flag cleared without write");
    rise_cause_a: assert property ($rose(disable_req_o[k]) |-> !$past(pin_n[k]) ||
      !$past(pin_n[k], 2) || !$past(pin_n[k], 3) || !$past(pin_n[k], 4) || !$past(pin_n[k], 5))
      else $error("flag set with pin high");
  end
  cover property ($rose(disable_req_o[0]));
  cover property ($fell(disable_req_o[2]));
  cover property ($fell(irq_o));
endmodule

bind output_disable_input_detect odid_props odid_props_inst (.sys_clk_i, .rst_n_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .disable_request_pin_b_n_i,
  .disable_request_pin_c_n_i, .disable_request_pin_d_n_i, .disable_request_pin_e_n_i,
  .disable_req_o, .irq_o);
`default_nettype wire

// ===== verification/fault_source.sv
// Model of the external fault sources on the four request pins.
// Assumes the bench commands a low request per pin on the same clock.
`timescale 1ns/1ns
`default_nettype none

module fault_source (
  // Clock and command
  input  wire logic       sys_clk_i,
  input  wire logic [3:0] low_cmd_i,
  // Request pins
  output logic            pin_b_n_o,
  output logic            pin_c_n_o,
  output logic            pin_d_n_o,
  output logic            pin_e_n_o
);
  logic [3:0] pin_n_reg = 4'hf;
  // Held low for a whole episode; released means driven high
  always @(posedge sys_clk_i) begin
    pin_n_reg <= ~low_cmd_i;
  end
  assign {pin_e_n_o, pin_d_n_o, pin_c_n_o, pin_b_n_o} = pin_n_reg;
endmodule
`default_nettype wire

// ===== verification/output_disable_input_detect_tb_top.sv
// Self-checking bench for the input-level detectors.
// Assumes the checker is bound in and the fault source model drives the pins.
`timescale 1ns/1ns
`default_nettype none

module output_disable_input_detect_tb_top
  import odid_pkg::*;
;
  logic              sys_clk_i;
  logic              rst_n_i;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [DATA_W-1:0] reg_wdata_i;
  logic              reg_wr_i;
  logic              reg_rd_i;
  wire  [DATA_W-1:0] reg_rdata_o;
  wire               pin_b_n, pin_c_n, pin_d_n, pin_e_n;
  wire  [NUM_CH-1:0] disable_req_o;
  wire               irq_o;
  logic [3:0]        low_cmd;
  int                n_errors = 0;
  int                n_checks = 0;
  int                div_tab [7] = '{0, 8, 16, 128, 1, 2, 4};

  output_disable_input_detect output_disable_input_detect_inst (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .disable_request_pin_b_n_i(pin_b_n), .disable_request_pin_c_n_i(pin_c_n),
    .disable_request_pin_d_n_i(pin_d_n), .disable_request_pin_e_n_i(pin_e_n),
    .disable_req_o(disable_req_o), .irq_o(irq_o));
  fault_source fault_source_inst (.sys_clk_i(sys_clk_i), .low_cmd_i(low_cmd),
    .pin_b_n_o(pin_b_n), .pin_c_n_o(pin_c_n), .pin_d_n_o(pin_d_n), .pin_e_n_o(pin_e_n));

  always #10 sys_clk_i = ~sys_clk_i;

  //////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // Callers never chain two writes: the strobe would be driven twice in one step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'h1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    reg_addr_i <= a;
    reg_rd_i <= 1'h1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'h0;
    @(negedge sys_clk_i);
    d = reg_rdata_o;
    @(posedge sys_clk_i);
  endtask
  task automatic wait_req(input int k, input int lim);
    int i;
    for (i = 0; i < lim && disable_req_o[k] !== 1'h1; i++)
      @(posedge sys_clk_i);
    if (i == lim) begin
      n_errors++;
      summarize();
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [15:0] d;
    for (int k = 0; k < 4; k++) begin
      rd(CH_OFS[k], d);
      chk(d, 16'h2000);
    end
    rd(OFS_IRQ_MASK, d);
    chk(d, 16'h0000);
    rd(4'hc, d);
    chk(d, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_edge();
    logic [15:0] d;
    low_cmd[0] <= 1'h1;
    wait_req(0, 10);
    chk({12'h0, disable_req_o}, 16'h0001);
    wr(OFS_CTRL_B, 16'h0000);
    cyc(2);
    chk({12'h0, disable_req_o}, 16'h0001);
    rd(OFS_CTRL_B, d);
    chk(d, 16'h1000);
    chk({15'h0, irq_o}, 16'h0000);
    wr(OFS_IRQ_MASK, 16'h000f);
    cyc(3);
    chk({15'h0, irq_o}, 16'h0001);
    rd(OFS_IRQ_STAT, d);
    chk(d, 16'h0001);
    cyc(2);
    chk({15'h0, irq_o}, 16'h0000);
    // Edge mode clears even while the pin is still low
    rd(OFS_CTRL_B, d);
    wr(OFS_CTRL_B, 16'h0000);
    cyc(2);
    chk({12'h0, disable_req_o}, 16'h0000);
    low_cmd[0] <= 1'h0;
    cyc(4);
    $display("test edge done");
  endtask
  task automatic t_modes();
    logic [15:0] d;
    logic [15:0] cfg;
    int dv;
    int k;
    for (int m = 1; m < 7; m++) begin
      dv = div_tab[m];
      k = m % 4;
      cfg = 16'h0020 | 16'(m);
      wr(CH_OFS[k], cfg);
      cyc(2);
      low_cmd[k] <= 1'h1;
      cyc(2 * dv);
      chk({15'h0, disable_req_o[k]}, 16'h0000);
      wait_req(k, dv + 10);
      rd(CH_OFS[k], d);
      wr(CH_OFS[k], cfg);
      cyc(2);
      chk({15'h0, disable_req_o[k]}, 16'h0001);
      low_cmd[k] <= 1'h0;
      cyc(4);
      rd(CH_OFS[k], d);
      wr(CH_OFS[k], cfg);
      rd(CH_OFS[k], d);
      chk(d, cfg | 16'h2000);
      chk({15'h0, disable_req_o[k]}, 16'h0000);
    end
    $display("test modes done");
  endtask
  task automatic t_mid_reset();
    logic [15:0] d;
    wr(OFS_CTRL_E, 16'h0000);
    low_cmd[3] <= 1'h1;
    wait_req(3, 10);
    chk({12'h0, disable_req_o}, 16'h0008);
    chk({15'h0, irq_o}, 16'h0001);
    rst_n_i <= 1'h0;
    cyc(2);
    rst_n_i <= 1'h1;
    cyc(1);
    chk({11'h0, irq_o, disable_req_o}, 16'h0000);
    rd(OFS_IRQ_MASK, d);
    chk(d, 16'h0000);
    // Pin still low: synchroniser resets high, so release gives a fresh edge
    wait_req(3, 10);
    rd(OFS_CTRL_E, d);
    chk(d, 16'h1000);
    low_cmd[3] <= 1'h0;
    cyc(4);
    wr(OFS_CTRL_E, 16'h0000);
    cyc(2);
    chk({15'h0, irq_o}, 16'h0000);
    chk({12'h0, disable_req_o}, 16'h0000);
    $display("test mid reset done");
  endtask

  initial begin
    sys_clk_i = 1'h0;
    rst_n_i = 1'h0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 16'h0000;
    reg_wr_i = 1'h0;
    reg_rd_i = 1'h0;
    low_cmd = 4'h0;
    cyc(2);
    rst_n_i <= 1'h1;
    cyc(1);
    t_reset();
    t_edge();
    t_modes();
    t_mid_reset();
    summarize();
  end
endmodule
`default_nettype wire
